// file: rtcpit_defines.svh
// Register indices, field positions, reset values and response codes of the compare and PIT block
// Summary of operation
// - Compare value is two bytes: low at index 0x0C, high at 0x0D.
// - Period field bits 6:3 picks 4..32768 RTC cycles; 0 off, 15 reserved.
// - Control bit 0 enables the periodic timer; reset disabled.
// - Sync status bit 0 reads 1 while a control write is synchronising.
// - Interrupt-control bit 0 enables the periodic interrupt; reset disabled.
// - Periodic flag bit 0 sets on each periodic interrupt.
// - Writing 1 clears the periodic flag; writing 0 leaves it.
// - Debug-run 0 and CPU halted: periodic timer stops and ignores events.
// - Debug-run 1: timer keeps counting and interrupting while CPU halted.
// - Compare-match flag bit 1 sets on counter equal compare; write 1 clears.
// - Shared temporary byte at index 0x04 stages 16-bit compare accesses.
`ifndef RTCPIT_DEFINES_SVH
`define RTCPIT_DEFINES_SVH
`define RTCPIT_IDX_INTCTRL 6'h02
`define RTCPIT_IDX_INTFLAGS 6'h03
`define RTCPIT_IDX_TEMP 6'h04
`define RTCPIT_IDX_COMPARE_LOW_BYTE 6'h0C
`define RTCPIT_IDX_COMPARE_HIGH_BYTE 6'h0D
`define RTCPIT_IDX_PITCTL 6'h10
`define RTCPIT_IDX_PITSYNC 6'h11
`define RTCPIT_IDX_PITIE 6'h12
`define RTCPIT_IDX_PITFLAG 6'h13
`define RTCPIT_IDX_PITDBG 6'h15
`define RTCPIT_PER_MSB 6
`define RTCPIT_PER_LSB 3
`define RTCPIT_EN_BIT 0
`define RTCPIT_PI_BIT 0
`define RTCPIT_CMP_BIT 1
`define RTCPIT_PER_MAX 4'hE
`define RTCPIT_RST_CMP 16'h0000
`define RTCPIT_RST_BYTE 8'h00
`define RTCPIT_RESP_OKAY 2'h0
`define RTCPIT_RESP_SLVERR 2'h2
`endif

// file: rtcpit_pkg.sv
// Types shared by the compare and periodic interrupt timer block
package rtcpit_pkg;
  typedef logic [3:0] rtcpit_period_t;
  // Control synchronisation into the RTC tick domain, one-hot
  typedef enum logic [2:0] {
    RTCPIT_SYNC_IDLE = 3'b001,
    RTCPIT_SYNC_ONE = 3'b010,
    RTCPIT_SYNC_TWO = 3'b100
  } rtcpit_sync_t;
endpackage

// file: rtcpit_top.sv
// Compare register, periodic interrupt timer and AXI4-Lite register slave
`timescale 1ns/100ps
`include "rtcpit_defines.svh"
module rtcpit_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rtc_tick,
  input wire logic [15:0] counter_value,
  input wire logic cpu_halted,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);
  logic aw_full_reg;
  logic w_full_reg;
  logic [5:0] aw_idx_reg;
  logic [7:0] wbyte_reg;
  logic wlane_reg;
  logic wr_do;
  logic rd_do;
  logic [5:0] ar_idx;
  logic wr_ok;
  logic rd_ok;
  logic [7:0] rd_val;
  logic [15:0] compare_reg;
  logic [7:0] temp_reg;
  logic [6:0] ctl_shadow_reg;
  logic act_en_reg;
  rtcpit_pkg::rtcpit_period_t act_period_reg;
  rtcpit_pkg::rtcpit_sync_t sync_reg;
  logic control_sync_busy;
  logic pit_ie_reg;
  logic cmp_ie_reg;
  logic periodic_irq_reg;
  logic cmp_flag_reg;
  logic run_in_debug_halt_reg;
  logic [14:0] pit_cnt_reg;
  logic [14:0] pit_mask;
  logic pit_run;
  logic pit_fire;
  logic cmp_hit;
  logic wr_ctl;

  // Byte registers take lane 0 only; index is the word address
  assign wr_do = aw_full_reg && w_full_reg && !s_axi_bvalid;
  assign rd_do = s_axi_arvalid && s_axi_arready;
  assign ar_idx = s_axi_araddr[7:2];
  assign wr_ctl = wr_do && wr_ok && wlane_reg && aw_idx_reg == `RTCPIT_IDX_PITCTL;
  assign control_sync_busy = sync_reg != rtcpit_pkg::RTCPIT_SYNC_IDLE;

  // Address map check, shared by both directions
  function automatic logic idx_mapped(input logic [5:0] idx);
    idx_mapped = idx == `RTCPIT_IDX_INTCTRL || idx == `RTCPIT_IDX_INTFLAGS ||
      idx == `RTCPIT_IDX_TEMP || idx == `RTCPIT_IDX_COMPARE_LOW_BYTE || idx == `RTCPIT_IDX_COMPARE_HIGH_BYTE ||
      idx == `RTCPIT_IDX_PITCTL || idx == `RTCPIT_IDX_PITSYNC ||
      idx == `RTCPIT_IDX_PITIE || idx == `RTCPIT_IDX_PITFLAG || idx == `RTCPIT_IDX_PITDBG;
  endfunction
  assign wr_ok = idx_mapped(aw_idx_reg);
  assign rd_ok = idx_mapped(ar_idx);

  // Write address and data are taken independently, in either order
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_idx_reg <= 6'h00;
      wbyte_reg <= 8'h00;
      wlane_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RTCPIT_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full_reg <= 1'b1;
        s_axi_awready <= 1'b0;
        aw_idx_reg <= s_axi_awaddr[7:2];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full_reg <= 1'b1;
        s_axi_wready <= 1'b0;
        wbyte_reg <= s_axi_wdata[7:0];
        wlane_reg <= s_axi_wstrb[0];
      end
      if (wr_do)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `RTCPIT_RESP_OKAY : `RTCPIT_RESP_SLVERR;
      end
      // Release both channels only after the response is taken
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read data mux; reserved bits read as zero, except control bits 2:1, which read back as written
  always_comb
  begin
    rd_val = 8'h00;
    if (ar_idx == `RTCPIT_IDX_INTCTRL)
      rd_val[`RTCPIT_CMP_BIT] = cmp_ie_reg;
    else if (ar_idx == `RTCPIT_IDX_INTFLAGS)
      rd_val[`RTCPIT_CMP_BIT] = cmp_flag_reg;
    else if (ar_idx == `RTCPIT_IDX_TEMP)
      rd_val = temp_reg;
    else if (ar_idx == `RTCPIT_IDX_COMPARE_LOW_BYTE)
      rd_val = compare_reg[7:0];
    else if (ar_idx == `RTCPIT_IDX_COMPARE_HIGH_BYTE)
      rd_val = temp_reg;
    else if (ar_idx == `RTCPIT_IDX_PITCTL)
      rd_val = {1'b0, ctl_shadow_reg};
    else if (ar_idx == `RTCPIT_IDX_PITSYNC)
      rd_val[0] = control_sync_busy;
    else if (ar_idx == `RTCPIT_IDX_PITIE)
      rd_val[0] = pit_ie_reg;
    else if (ar_idx == `RTCPIT_IDX_PITFLAG)
      rd_val[`RTCPIT_PI_BIT] = periodic_irq_reg;
    else if (ar_idx == `RTCPIT_IDX_PITDBG)
      rd_val[0] = run_in_debug_halt_reg;
  end

  // Read answers one cycle after the address is taken
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RTCPIT_RESP_OKAY;
    end
    else if (rd_do)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_val};
      s_axi_rresp <= rd_ok ? `RTCPIT_RESP_OKAY : `RTCPIT_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Temporary byte: low write stages, low read latches the high byte
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      temp_reg <= `RTCPIT_RST_BYTE;
    else if (wr_do && wlane_reg &&
      (aw_idx_reg == `RTCPIT_IDX_TEMP || aw_idx_reg == `RTCPIT_IDX_COMPARE_LOW_BYTE))
      temp_reg <= wbyte_reg;
    else if (rd_do && ar_idx == `RTCPIT_IDX_COMPARE_LOW_BYTE)
      temp_reg <= compare_reg[15:8];
  end

  // Both bytes land together on the high-byte write, so compare never tears
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      compare_reg <= `RTCPIT_RST_CMP;
    else if (wr_do && wlane_reg && aw_idx_reg == `RTCPIT_IDX_COMPARE_HIGH_BYTE)
      compare_reg <= {wbyte_reg, temp_reg};
  end

  // Plain control bits
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pit_ie_reg <= 1'b0;
      cmp_ie_reg <= 1'b0;
      run_in_debug_halt_reg <= 1'b0;
      ctl_shadow_reg <= 7'h00;
    end
    else if (wr_do && wr_ok && wlane_reg)
    begin
      if (aw_idx_reg == `RTCPIT_IDX_PITIE)
        pit_ie_reg <= wbyte_reg[0];
      else if (aw_idx_reg == `RTCPIT_IDX_INTCTRL)
        cmp_ie_reg <= wbyte_reg[`RTCPIT_CMP_BIT];
      else if (aw_idx_reg == `RTCPIT_IDX_PITDBG)
        run_in_debug_halt_reg <= wbyte_reg[0];
      else if (aw_idx_reg == `RTCPIT_IDX_PITCTL)
        ctl_shadow_reg <= wbyte_reg[6:0];
    end
  end

  // Control write needs two RTC ticks to take effect; a new write restarts it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_reg <= rtcpit_pkg::RTCPIT_SYNC_IDLE;
      act_en_reg <= 1'b0;
      act_period_reg <= 4'h0;
    end
    else if (wr_ctl)
      sync_reg <= rtcpit_pkg::RTCPIT_SYNC_ONE;
    else if (rtc_tick)
    begin
      case (sync_reg)
        rtcpit_pkg::RTCPIT_SYNC_ONE: sync_reg <= rtcpit_pkg::RTCPIT_SYNC_TWO;
        rtcpit_pkg::RTCPIT_SYNC_TWO:
        begin
          sync_reg <= rtcpit_pkg::RTCPIT_SYNC_IDLE;
          act_en_reg <= ctl_shadow_reg[`RTCPIT_EN_BIT];
          act_period_reg <= ctl_shadow_reg[`RTCPIT_PER_MSB:`RTCPIT_PER_LSB];
        end
        default: sync_reg <= rtcpit_pkg::RTCPIT_SYNC_IDLE;
      endcase
    end
  end

  // Interval is 2^(code+1) ticks; mask selects the low bits that must be all ones
  assign pit_mask = 15'((16'h0002 << act_period_reg) - 16'h0001);
  assign pit_run = act_en_reg && rtc_tick && (run_in_debug_halt_reg || !cpu_halted);
  assign pit_fire = pit_run && act_period_reg != 4'h0 &&
    act_period_reg <= `RTCPIT_PER_MAX && (pit_cnt_reg & pit_mask) == pit_mask;
  assign cmp_hit = rtc_tick && counter_value == compare_reg;

  // Prescale counter; frozen while halted with debug-run 0, cleared while disabled
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pit_cnt_reg <= 15'h0000;
    else if (!act_en_reg)
      pit_cnt_reg <= 15'h0000;
    else if (pit_run)
      pit_cnt_reg <= pit_cnt_reg + 15'h0001;
  end

  // Sticky flags: a set in the same cycle as a clear wins
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      periodic_irq_reg <= 1'b0;
      cmp_flag_reg <= 1'b0;
    end
    else
    begin
      if (pit_fire)
        periodic_irq_reg <= 1'b1;
      else if (wr_do && wlane_reg && aw_idx_reg == `RTCPIT_IDX_PITFLAG &&
        wbyte_reg[`RTCPIT_PI_BIT])
        periodic_irq_reg <= 1'b0;
      if (cmp_hit)
        cmp_flag_reg <= 1'b1;
      else if (wr_do && wlane_reg && aw_idx_reg == `RTCPIT_IDX_INTFLAGS &&
        wbyte_reg[`RTCPIT_CMP_BIT])
        cmp_flag_reg <= 1'b0;
    end
  end

  // Level interrupt, one cycle behind the flags
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= (periodic_irq_reg && pit_ie_reg) || (cmp_flag_reg && cmp_ie_reg);
  end

  sequence s_ctl_write;
    wr_ctl;
  endsequence
  // Second tick of a pending control write, with no newer write restarting it
  sequence s_second_tick;
    rtc_tick && !wr_ctl && sync_reg == rtcpit_pkg::RTCPIT_SYNC_TWO;
  endsequence

  a_pit_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
    pit_fire |=> periodic_irq_reg)
    else $error("periodic flag not set after fire");
  a_pit_flag_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_do && wlane_reg && aw_idx_reg == `RTCPIT_IDX_PITFLAG && wbyte_reg[0] && !pit_fire)
    |=> !periodic_irq_reg)
    else $error("periodic flag not cleared by write one");
  a_pit_flag_keep: assert property (@(posedge clk) disable iff (!rst_n)
    (periodic_irq_reg && !(wr_do && aw_idx_reg == `RTCPIT_IDX_PITFLAG)) |=> periodic_irq_reg)
    else $error("periodic flag lost");
  a_cmp_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
    cmp_hit |=> cmp_flag_reg)
    else $error("compare flag not set on match");
  a_busy_after_write: assert property (@(posedge clk) disable iff (!rst_n)
    s_ctl_write |=> control_sync_busy [*1] ##0 !act_en_reg == !$past(act_en_reg))
    else $error("busy not raised by control write");
  a_sync_commit: assert property (@(posedge clk) disable iff (!rst_n)
    s_second_tick |=> !control_sync_busy && act_en_reg == ctl_shadow_reg[`RTCPIT_EN_BIT] &&
    act_period_reg == ctl_shadow_reg[`RTCPIT_PER_MSB:`RTCPIT_PER_LSB])
    else $error("control settings not applied on second tick");
  a_busy_ends_tick: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(control_sync_busy) |-> $past(rtc_tick))
    else $error("busy ended without a tick");
  a_halt_freeze: assert property (@(posedge clk) disable iff (!rst_n)
    (act_en_reg && cpu_halted && !run_in_debug_halt_reg) |=> $stable(pit_cnt_reg))
    else $error("timer ran while halted");
  a_halt_run: assert property (@(posedge clk) disable iff (!rst_n)
    (act_en_reg && rtc_tick && run_in_debug_halt_reg) |=>
    pit_cnt_reg == 15'($past(pit_cnt_reg) + 15'h0001))
    else $error("timer stopped with debug run set");
  a_period_off: assert property (@(posedge clk) disable iff (!rst_n)
    (act_period_reg == 4'h0 || act_period_reg == 4'hF) |-> !pit_fire)
    else $error("fire with period off or reserved");
  a_cmp_commit: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_do && wlane_reg && aw_idx_reg == `RTCPIT_IDX_COMPARE_HIGH_BYTE) |=>
    compare_reg == {$past(wbyte_reg), $past(temp_reg)})
    else $error("compare high write did not commit");
  a_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
    (periodic_irq_reg && pit_ie_reg) |=> irq)
    else $error("interrupt not raised");
  a_irq_drop: assert property (@(posedge clk) disable iff (!rst_n)
    (!periodic_irq_reg || !pit_ie_reg) && (!cmp_flag_reg || !cmp_ie_reg) |=> !irq)
    else $error("interrupt held without cause");
endmodule // rtcpit_top

// file: tb_rtcpit_top.sv
// Self-checking testbench for the compare register and periodic interrupt timer
`timescale 1ns/100ps
`include "rtcpit_defines.svh"
module tb_rtcpit_top;
  localparam int TDIV = 8;
  localparam logic [7:0] A_CIE = {`RTCPIT_IDX_INTCTRL, 2'b00};
  localparam logic [7:0] A_CIF = {`RTCPIT_IDX_INTFLAGS, 2'b00};
  localparam logic [7:0] A_TMP = {`RTCPIT_IDX_TEMP, 2'b00};
  localparam logic [7:0] A_CL = {`RTCPIT_IDX_COMPARE_LOW_BYTE, 2'b00};
  localparam logic [7:0] A_CH = {`RTCPIT_IDX_COMPARE_HIGH_BYTE, 2'b00};
  localparam logic [7:0] A_CTL = {`RTCPIT_IDX_PITCTL, 2'b00};
  localparam logic [7:0] A_SYN = {`RTCPIT_IDX_PITSYNC, 2'b00};
  localparam logic [7:0] A_IE = {`RTCPIT_IDX_PITIE, 2'b00};
  localparam logic [7:0] A_FLG = {`RTCPIT_IDX_PITFLAG, 2'b00};
  localparam logic [7:0] A_DBG = {`RTCPIT_IDX_PITDBG, 2'b00};
  logic clk, rst_n, rtc_tick, cpu_halted, irq;
  logic [15:0] counter_value;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, seed;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int error_cnt, total_checks, div_cnt;
  logic [7:0] rst_addr [10] = '{A_CIE, A_CIF, A_TMP, A_CL, A_CH, A_CTL, A_SYN, A_IE, A_FLG,
    A_DBG};

  rtcpit_top uut (.clk(clk), .rst_n(rst_n), .rtc_tick(rtc_tick), .counter_value(counter_value),
    .cpu_halted(cpu_halted), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq(irq));

  // Free-running clock
  always #5 clk = ~clk;

  // Slow tick and RTC counter, kept away from compare value zero
  always @(posedge clk)
  begin
    if (rst_n)
    begin
      div_cnt <= (div_cnt == TDIV - 1) ? 0 : div_cnt + 1;
      rtc_tick <= (div_cnt == TDIV - 1);
      if (rtc_tick) counter_value <= counter_value + 16'h0001;
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [7:0] ctl_byte(input logic [3:0] c, input logic en);
    return {1'b0, c, 2'b00, en};
  endfunction

  // Ticks between fires for a period code
  function automatic logic [31:0] period_ticks(input int c);
    return 32'h1 << (c + 1);
  endfunction

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task complete_run;
    $display("Checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Both write channels offered together, each released when taken
  task axi_write(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    bit aw_done, w_done;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_done = 0;
    w_done = 0;
    while (!(aw_done && w_done))
    begin
      @(posedge clk);
      if (!aw_done && awready === 1'b1)
      begin
        aw_done = 1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1)
      begin
        w_done = 1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge clk);
    r = bresp;
    bready <= 1'b0;
  endtask

  task axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    check("bresp", r, `RTCPIT_RESP_OKAY);
  endtask

  task rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    check(name, d, exp);
    check("rresp", r, `RTCPIT_RESP_OKAY);
  endtask

  // Wait for irq to drop, then to rise, each within lim cycles
  task wait_rise(input int lim, output bit got);
    int n;
    n = 0;
    while (irq === 1'b1 && n < lim)
    begin
      @(posedge clk);
      n++;
    end
    n = 0;
    while (irq !== 1'b1 && n < lim)
    begin
      @(posedge clk);
      n++;
    end
    got = (irq === 1'b1);
  endtask

  // Hang guard, well above the whole sequence
  initial
  begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    complete_run;
  end

  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] lo, hi, tb;
    logic [15:0] cmpv, t0, dt;
    bit got;
    int lim;
    clk = 0; rst_n = 0; rtc_tick = 0; cpu_halted = 0; counter_value = 16'h0100; div_cnt = 0;
    awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'h0; seed = 32'h00000053;
    awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    error_cnt = 0; total_checks = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rst_addr[i]) rd_chk("reset value", rst_addr[i], 32'h0);
    // Unmapped place: error response, no data
    axi_read(8'hF8, d, r);
    check("unmapped rdata", d, 32'h0);
    check("unmapped rresp", r, `RTCPIT_RESP_SLVERR);
    axi_write(8'hF8, 8'hFF, r);
    check("unmapped bresp", r, `RTCPIT_RESP_SLVERR);
    // Compare pair through the shared staging byte, random values
    repeat (4)
    begin
      seed = xs(seed);
      lo = seed[7:0];
      hi = seed[15:8];
      tb = seed[23:16];
      wr(A_CL, lo);
      wr(A_CH, hi);
      rd_chk("cmp low", A_CL, {24'h0, lo});
      rd_chk("temp copy", A_TMP, {24'h0, hi});
      rd_chk("cmp high", A_CH, {24'h0, hi});
      wr(A_TMP, tb);
      wr(A_CH, lo);
      rd_chk("cmp low staged", A_CL, {24'h0, tb});
      rd_chk("cmp high staged", A_CH, {24'h0, lo});
    end
    // Compare match a few ticks ahead, then clear by writing one
    cmpv = counter_value + 16'h0028;
    wr(A_CIE, 8'h02);
    wr(A_CL, cmpv[7:0]);
    wr(A_CH, cmpv[15:8]);
    repeat (60 * TDIV) @(posedge clk);
    check("cmp irq", irq, 32'h1);
    rd_chk("cmp flag", A_CIF, 32'h2);
    rd_chk("cmp enable", A_CIE, 32'h2);
    wr(A_CIF, 8'h02);
    rd_chk("cmp flag clear", A_CIF, 32'h0);
    check("cmp irq clear", irq, 32'h0);
    wr(A_CIE, 8'h00);
    // Fire interval for each short period code
    wr(A_IE, 8'h01);
    for (int c = 1; c <= 6; c++)
    begin
      lim = 2 * period_ticks(c) * TDIV + 64;
      wr(A_CTL, ctl_byte(c[3:0], 1'b1));
      rd_chk("sync busy", A_SYN, 32'h1);
      wr(A_FLG, 8'h01);
      wait_rise(lim, got);
      wr(A_FLG, 8'h01);
      wait_rise(lim, got);
      t0 = counter_value;
      wr(A_FLG, 8'h01);
      wait_rise(lim, got);
      dt = counter_value - t0;
      check("pit interval", {16'h0, dt}, period_ticks(c));
      rd_chk("pit flag", A_FLG, 32'h1);
      rd_chk("sync idle", A_SYN, 32'h0);
    end
    // Off and reserved codes never fire
    for (int k = 0; k < 2; k++)
    begin
      wr(A_CTL, ctl_byte(k ? 4'hF : 4'h0, 1'b1));
      repeat (4 * TDIV) @(posedge clk);
      wr(A_FLG, 8'h01);
      wait_rise(100 * TDIV, got);
      check("no fire", got, 1'b0);
    end
    // Masked request: flag sets, irq stays low, writing zero keeps the flag
    wr(A_CTL, ctl_byte(4'h1, 1'b1));
    wr(A_IE, 8'h00);
    repeat (20 * TDIV) @(posedge clk);
    rd_chk("flag masked", A_FLG, 32'h1);
    check("irq masked", irq, 32'h0);
    // Stop new fires first, so a wrongly cleared flag cannot be set again unseen
    wr(A_CTL, ctl_byte(4'h0, 1'b1));
    repeat (4 * TDIV) @(posedge clk);
    wr(A_FLG, 8'h00);
    rd_chk("flag kept", A_FLG, 32'h1);
    wr(A_IE, 8'h01);
    wait_rise(8, got);
    check("irq unmasked", got, 1'b1);
    // Debug halt stops the timer unless run-in-halt is set
    wr(A_CTL, ctl_byte(4'h2, 1'b1));
    wr(A_DBG, 8'h00);
    @(posedge clk);
    cpu_halted <= 1'b1;
    repeat (4 * TDIV) @(posedge clk);
    wr(A_FLG, 8'h01);
    wait_rise(40 * TDIV, got);
    check("halted no fire", got, 1'b0);
    wr(A_DBG, 8'h01);
    rd_chk("debug run", A_DBG, 32'h1);
    wait_rise(20 * TDIV, got);
    check("run in halt", got, 1'b1);
    @(posedge clk);
    cpu_halted <= 1'b0;
    // Disabled timer stays quiet
    wr(A_CTL, ctl_byte(4'h2, 1'b0));
    rd_chk("ctl readback", A_CTL, {24'h0, ctl_byte(4'h2, 1'b0)});
    repeat (4 * TDIV) @(posedge clk);
    wr(A_FLG, 8'h01);
    wait_rise(40 * TDIV, got);
    check("disabled", got, 1'b0);
    complete_run;
  end
endmodule // tb_rtcpit_top
